// >>> cpwm_defs.svh
// Register offsets, field positions, reset values and notes for the complementary PWM block
//
// Functional notes
// RULE1: Each pair is driven from one compare signal; low side is its inverse.
// RULE2: With dead time enabled both outputs of a pair sit low at each switch.
// RULE3: Four duty comparators; comparator n drives output pair n.
// RULE4: A cleared per-pair mode bit in the first control register selects complementary.
// RULE5: Every pair comes out of reset in complementary operation.
// RULE6: Only complementary pairs receive dead time; other pairs get none.
// RULE7: Two programmable dead times, A and B, shared among all pairs.
// RULE8: One dead time separates low-side turn-off from following high-side turn-on.
// RULE9: The other separates high-side turn-off from following low-side turn-on.
// RULE10: A whole pair may use one chosen dead time, differing between pairs.
// RULE11: Every pair has its own 6-bit down counter timing its dead time.
// RULE12: Rising and falling compare edges are both detected and each starts dead time.
// RULE13: Per pair, one assign bit picks the active-edge and one the inactive-edge time.
// RULE14: Each dead time has a 2-bit prescale select of 1, 2, 4 or 8 cycles.
// RULE15: Dead time equals its 6-bit count times the prescaled period.
// RULE16: Prescalers clear on counter load, on dead-time register write and on reset.
// RULE17: Software leaves dead-time registers alone while the time base runs.
// RULE18: Cleared select bit chooses dead time A, set bit chooses dead time B.
// RULE19: Outgoing output turns off at once; the other turns on at count zero.
`ifndef CPWM_DEFS_SVH
`define CPWM_DEFS_SVH

// Register word offsets
`define CPWM_ADDR_CTRL     4'h0
`define CPWM_ADDR_TBASE    4'h1
`define CPWM_ADDR_PERIOD   4'h2
`define CPWM_ADDR_DTVAL    4'h3
`define CPWM_ADDR_DTASSIGN 4'h4
`define CPWM_ADDR_DUTY1    4'h5
`define CPWM_ADDR_DUTY4    4'h8
`define CPWM_ADDR_STATUS   4'h9
`define CPWM_ADDR_TBCNT    4'hA

// Field positions
`define CPWM_TBON_BIT      0
`define CPWM_DTA_LSB       0
`define CPWM_DTB_LSB       8

// Reset values
`define CPWM_CTRL_RST      4'h0
`define CPWM_TBASE_RST     1'b0
`define CPWM_PERIOD_RST    16'h00FF
`define CPWM_DTVAL_RST     16'h0000
`define CPWM_DTASSIGN_RST  8'h00
`define CPWM_DUTY_RST      16'h0000

`endif

// >>> cpwm_pkg.sv
// Types shared by the complementary PWM block
package cpwm_pkg;
	// One dead-time setting: prescale select and count
	typedef struct packed {
		logic [1:0] prescale;
		logic [5:0] count;
	} cpwm_dt_cfg_t;

	// One output pair
	typedef struct packed {
		logic high;
		logic low;
	} cpwm_pair_t;

	// Dead-time unit state
	typedef enum logic {
		CPWM_DRIVE,
		CPWM_DEAD
	} cpwm_state_t;
endpackage

// >>> cpwm_deadtime.sv
// Per-pair dead-time unit: edge detect, 6-bit down counter, prescaler
module cpwm_deadtime (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	// Control
	input  wire logic                  cmp,
	input  wire logic                  comp_mode,
	input  wire cpwm_pkg::cpwm_dt_cfg_t dt_a,
	input  wire cpwm_pkg::cpwm_dt_cfg_t dt_b,
	input  wire logic                  sel_act,
	input  wire logic                  sel_inact,
	input  wire logic                  pre_clr,
	// Pair drive
	output cpwm_pkg::cpwm_pair_t       pair_o
);
	import cpwm_pkg::*;

	logic         lvl;
	logic [5:0]   cnt;
	logic [2:0]   pre;
	logic [1:0]   ps;
	cpwm_state_t  st;
	cpwm_dt_cfg_t chosen;
	logic         sw_edge;
	logic [2:0]   lim;

	// Edge detect and time choice per edge direction
	assign sw_edge = cmp ^ lvl; // [RULE12]
	assign chosen = cmp ? (sel_act ? dt_b : dt_a) : (sel_inact ? dt_b : dt_a); // [RULE8] [RULE9] [RULE13] [RULE18]
	assign lim = 3'((4'h1 << ps) - 4'h1); // [RULE14]

	// Counter, prescaler and state
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lvl <= 1'b0;
			cnt <= 6'h00;
			pre <= 3'h0; // [RULE16]
			ps  <= 2'h0;
			st  <= CPWM_DRIVE;
		end else if (ce) begin
			lvl <= cmp;
			if (!comp_mode) begin
				st  <= CPWM_DRIVE; // [RULE6]
				cnt <= 6'h00;
			end else if (sw_edge && chosen.count != 6'h00) begin
				cnt <= chosen.count; // [RULE11] [RULE15]
				ps  <= chosen.prescale;
				pre <= 3'h0; // [RULE16]
				st  <= CPWM_DEAD; // [RULE2]
			end else if (sw_edge) begin
				st  <= CPWM_DRIVE;
				cnt <= 6'h00;
			end else if (pre_clr) begin
				pre <= 3'h0; // [RULE16]
			end else if (st == CPWM_DEAD) begin
				if (pre == lim) begin
					pre <= 3'h0;
					cnt <= cnt - 6'h01;
					if (cnt == 6'h01)
						st <= CPWM_DRIVE; // [RULE19]
				end else begin
					pre <= pre + 3'h1;
				end
			end
		end
	end

	// Outgoing side drops with the level, incoming side waits for the count
	always_comb begin
		pair_o.high = (st == CPWM_DRIVE) && lvl; // [RULE19]
		pair_o.low  = (st == CPWM_DRIVE) && (comp_mode ? !lvl : lvl); // [RULE1]
	end

	// Helper: cycles spent in the current dead interval and the length it must reach;
	// a prescaler clear inside the interval stretches it, so such intervals are not judged
	logic [8:0] run;
	logic [8:0] span;
	logic       clean;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			run   <= 9'h000;
			span  <= 9'h000;
			clean <= 1'b0;
		end else if (ce) begin
			if (comp_mode && sw_edge && chosen.count != 6'h00) begin
				run   <= 9'h000;
				span  <= 9'(chosen.count) << chosen.prescale;
				clean <= 1'b1;
			end else if (st == CPWM_DEAD) begin
				run <= run + 9'h001;
				if (pre_clr)
					clean <= 1'b0;
			end else begin
				run <= 9'h000;
			end
		end
	end

	property dead_exit_p;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && st == CPWM_DEAD && pre == lim && cnt == 6'h01 && !sw_edge
			&& comp_mode && !pre_clr && clean) |-> (9'(run + 9'h001) == span);
	endproperty
	dead_len_a: assert property (dead_exit_p) else $error("dead interval length wrong"); // [RULE15]

	dead_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
		(ce && comp_mode && sw_edge && chosen.count != 6'h00)
		|=> (st == CPWM_DEAD && !pair_o.high && !pair_o.low))
		else $error("dead interval not entered on edge");
endmodule

// >>> cpwm_top.sv
// Complementary four-pair PWM with dead-time insertion and register port
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "cpwm_defs.svh"
module cpwm_top (
	// Clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Output pairs
	output logic             pair1_high_out,
	output logic             pair1_low_out,
	output logic             pair2_high_out,
	output logic             pair2_low_out,
	output logic             pair3_high_out,
	output logic             pair3_low_out,
	output logic             pair4_high_out,
	output logic             pair4_low_out
);
	import cpwm_pkg::*;

	// ********************************************
	// Register state
	// ********************************************

	logic [3:0]   pair_independent_select;
	logic         pwm_timebase_on;
	logic [15:0]  period;
	logic [15:0]  deadtime_value_ctrl;
	logic [7:0]   deadtime_assign_ctrl;
	logic [15:0]  duty_cycle_reg_1;
	logic [15:0]  duty_cycle_reg_2;
	logic [15:0]  duty_cycle_reg_3;
	logic [15:0]  duty_cycle_reg_4;
	logic [15:0]  tb_cnt;
	logic [15:0]  next_rdata;
	logic         pre_clr;
	logic [15:0]  duty [4];
	logic [3:0]   cmp;
	cpwm_pair_t   pair_raw [4];
	cpwm_pair_t   pair_q [4];
	cpwm_dt_cfg_t deadtime_a_cfg;
	cpwm_dt_cfg_t deadtime_b_cfg;
	logic [1:0]   deadtime_a_prescale;
	logic [1:0]   deadtime_b_prescale;
	logic [7:0]   out_bits;

	// Mode bits: cleared means complementary, cleared by reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			pair_independent_select <= `CPWM_CTRL_RST; // [RULE5]
		else if (ce && reg_wr && reg_addr == `CPWM_ADDR_CTRL)
			pair_independent_select <= reg_wdata[3:0]; // [RULE4]
	end

	// Time base enable
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			pwm_timebase_on <= `CPWM_TBASE_RST;
		else if (ce && reg_wr && reg_addr == `CPWM_ADDR_TBASE)
			pwm_timebase_on <= reg_wdata[`CPWM_TBON_BIT];
	end

	// Period register
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			period <= `CPWM_PERIOD_RST;
		else if (ce && reg_wr && reg_addr == `CPWM_ADDR_PERIOD)
			period <= reg_wdata;
	end

	// Dead-time values: count A, prescale A, count B, prescale B
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			deadtime_value_ctrl <= `CPWM_DTVAL_RST;
		else if (ce && reg_wr && reg_addr == `CPWM_ADDR_DTVAL)
			deadtime_value_ctrl <= reg_wdata; // [RULE7]
	end

	// Dead-time assignment: bit 2n active edge, bit 2n+1 inactive edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			deadtime_assign_ctrl <= `CPWM_DTASSIGN_RST;
		else if (ce && reg_wr && reg_addr == `CPWM_ADDR_DTASSIGN)
			deadtime_assign_ctrl <= reg_wdata[7:0]; // [RULE13]
	end

	// Duty-cycle registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			duty_cycle_reg_1 <= `CPWM_DUTY_RST;
			duty_cycle_reg_2 <= `CPWM_DUTY_RST;
			duty_cycle_reg_3 <= `CPWM_DUTY_RST;
			duty_cycle_reg_4 <= `CPWM_DUTY_RST;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				`CPWM_ADDR_DUTY1: duty_cycle_reg_1 <= reg_wdata;
				`CPWM_ADDR_DUTY1 + 4'h1: duty_cycle_reg_2 <= reg_wdata;
				`CPWM_ADDR_DUTY1 + 4'h2: duty_cycle_reg_3 <= reg_wdata;
				`CPWM_ADDR_DUTY4: duty_cycle_reg_4 <= reg_wdata;
				default: ;
			endcase
		end
	end

	// ********************************************
	// Dead-time field split
	// ********************************************

	// Both dead times carved from one register
	assign deadtime_a_cfg = deadtime_value_ctrl[`CPWM_DTA_LSB +: 8]; // [RULE7] [RULE14]
	assign deadtime_b_cfg = deadtime_value_ctrl[`CPWM_DTB_LSB +: 8]; // [RULE7] [RULE14]
	assign deadtime_a_prescale = deadtime_a_cfg.prescale;
	assign deadtime_b_prescale = deadtime_b_cfg.prescale;

	// Any write to either dead-time register restarts the prescalers
	assign pre_clr = reg_wr && (reg_addr == `CPWM_ADDR_DTVAL
		|| reg_addr == `CPWM_ADDR_DTASSIGN); // [RULE16]

	// ********************************************
	// Time base and comparators
	// ********************************************

	// Up counter wrapping at the period value
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			tb_cnt <= 16'h0000;
		else if (ce) begin
			if (!pwm_timebase_on)
				tb_cnt <= 16'h0000;
			else if (tb_cnt >= period)
				tb_cnt <= 16'h0000;
			else
				tb_cnt <= tb_cnt + 16'h0001;
		end
	end

	assign duty[0] = duty_cycle_reg_1;
	assign duty[1] = duty_cycle_reg_2;
	assign duty[2] = duty_cycle_reg_3;
	assign duty[3] = duty_cycle_reg_4;

	// One comparator and one dead-time unit per pair
	for (genvar n = 0; n < 4; n++) begin : g_pair
		assign cmp[n] = pwm_timebase_on && (tb_cnt < duty[n]); // [RULE3]

		cpwm_deadtime u_dt (
			.clk_sys   (clk_sys),
			.rst_n     (rst_n),
			.ce        (ce),
			.cmp       (cmp[n]),
			.comp_mode (!pair_independent_select[n]), // [RULE6]
			.dt_a      (deadtime_a_cfg),
			.dt_b      (deadtime_b_cfg),
			.sel_act   (deadtime_assign_ctrl[2*n]), // [RULE10]
			.sel_inact (deadtime_assign_ctrl[2*n+1]), // [RULE10]
			.pre_clr   (pre_clr),
			.pair_o    (pair_raw[n])
		);

		// Output flops
		always_ff @(posedge clk_sys) begin
			if (!rst_n)
				pair_q[n] <= '0;
			else if (ce)
				pair_q[n] <= pair_raw[n]; // [RULE1]
		end

		assign out_bits[2*n]   = pair_q[n].high;
		assign out_bits[2*n+1] = pair_q[n].low;

		no_shoot_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE1]
			(!pair_independent_select[n] && !$past(pair_independent_select[n]))
			|-> !(pair_q[n].high && pair_q[n].low))
			else $error("both outputs of a pair high");

		indep_same_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE6]
			(ce && $past(ce) && pair_independent_select[n]
				&& $past(pair_independent_select[n]))
			|=> (pair_q[n].high == pair_q[n].low))
			else $error("independent pair got complementary drive");

		// Compare edges with the unit running on two edges in a row
		sequence cmp_fall_s;
			ce && $fell(cmp[n]) ##1 ce;
		endsequence

		sequence cmp_rise_s;
			ce && $rose(cmp[n]) ##1 ce && !pair_independent_select[n];
		endsequence

		high_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE19]
			cmp_fall_s |=> !pair_q[n].high)
			else $error("high side late to turn off");

		low_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE19]
			cmp_rise_s |=> !pair_q[n].low)
			else $error("low side late to turn off");

		duty_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
			(ce && reg_wr && reg_addr == `CPWM_ADDR_DUTY1 + 4'(n))
			|=> duty[n] == $past(reg_wdata))
			else $error("duty value not stored");
	end

	assign pair1_high_out = pair_q[0].high;
	assign pair1_low_out  = pair_q[0].low;
	assign pair2_high_out = pair_q[1].high;
	assign pair2_low_out  = pair_q[1].low;
	assign pair3_high_out = pair_q[2].high;
	assign pair3_low_out  = pair_q[2].low;
	assign pair4_high_out = pair_q[3].high;
	assign pair4_low_out  = pair_q[3].low;

	// ********************************************
	// Read path
	// ********************************************

	// Read mux; unmapped addresses return zero
	always_comb begin
		next_rdata = 16'h0000;
		case (reg_addr)
			`CPWM_ADDR_CTRL: next_rdata = {12'h000, pair_independent_select};
			`CPWM_ADDR_TBASE: next_rdata = {15'h0000, pwm_timebase_on};
			`CPWM_ADDR_PERIOD: next_rdata = period;
			`CPWM_ADDR_DTVAL: next_rdata = deadtime_value_ctrl;
			`CPWM_ADDR_DTASSIGN: next_rdata = {8'h00, deadtime_assign_ctrl};
			`CPWM_ADDR_DUTY1: next_rdata = duty_cycle_reg_1;
			`CPWM_ADDR_DUTY1 + 4'h1: next_rdata = duty_cycle_reg_2;
			`CPWM_ADDR_DUTY1 + 4'h2: next_rdata = duty_cycle_reg_3;
			`CPWM_ADDR_DUTY4: next_rdata = duty_cycle_reg_4;
			`CPWM_ADDR_STATUS: next_rdata = {4'h0, cmp, out_bits};
			`CPWM_ADDR_TBCNT: next_rdata = tb_cnt;
			default: next_rdata = 16'h0000;
		endcase
	end

	// Read data stands for one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (ce)
			reg_rdata <= reg_rd ? next_rdata : 16'h0000;
	end

	// ********************************************
	// Checks
	// ********************************************

	sequence rd_unmapped_s;
		ce && reg_rd && reg_addr > `CPWM_ADDR_TBCNT;
	endsequence

	sequence rd_duty_s;
		ce && reg_rd && reg_addr == `CPWM_ADDR_DUTY1 && !reg_wr;
	endsequence

	unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rd_unmapped_s |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");

	duty_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
		rd_duty_s |=> reg_rdata == $past(duty_cycle_reg_1))
		else $error("duty read wrong");

	reset_mode_a: assert property (@(posedge clk_sys) // [RULE5]
		($past(rst_n) == 1'b0 && rst_n) |-> pair_independent_select == 4'h0
			&& pair_q[0] == '0 && reg_rdata == 16'h0000)
		else $error("pairs not complementary after reset");

	sequence dt_write_s;
		ce && reg_wr && reg_addr == `CPWM_ADDR_DTVAL;
	endsequence

	dt_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE7]
		dt_write_s |=> deadtime_value_ctrl == $past(reg_wdata))
		else $error("dead-time value not stored");

	freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ce |=> ($stable(out_bits) && $stable(tb_cnt)))
		else $error("state moved with enable low");

	tb_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ce && pwm_timebase_on && tb_cnt == period) |=> tb_cnt == 16'h0000)
		else $error("time base did not wrap");

	cmp_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
		!pwm_timebase_on |-> cmp == 4'h0)
		else $error("compare active with time base off");

	mode_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE4]
		(ce && reg_wr && reg_addr == `CPWM_ADDR_CTRL)
		|=> pair_independent_select == $past(reg_wdata[3:0]))
		else $error("mode bits not stored");

	period_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ce && reg_wr && reg_addr == `CPWM_ADDR_PERIOD) |=> period == $past(reg_wdata))
		else $error("period not stored");

	tbase_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ce && reg_wr && reg_addr == `CPWM_ADDR_TBASE)
		|=> pwm_timebase_on == $past(reg_wdata[`CPWM_TBON_BIT]))
		else $error("time base enable not stored");

	assign_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE13]
		(ce && reg_wr && reg_addr == `CPWM_ADDR_DTASSIGN)
		|=> deadtime_assign_ctrl == $past(reg_wdata[7:0]))
		else $error("dead-time assignment not stored");

	rd_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ce && !reg_rd) |=> reg_rdata == 16'h0000)
		else $error("read data stood longer than one cycle");

	rd_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ce |=> $stable(reg_rdata))
		else $error("read data moved with enable low");

	rd_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ce && reg_rd && reg_addr == `CPWM_ADDR_PERIOD)
		|=> reg_rdata == $past(period))
		else $error("period read wrong");

	rd_dtval_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE7]
		(ce && reg_rd && reg_addr == `CPWM_ADDR_DTVAL)
		|=> reg_rdata == $past(deadtime_value_ctrl))
		else $error("dead-time value read wrong");

	rd_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE4]
		(ce && reg_rd && reg_addr == `CPWM_ADDR_CTRL)
		|=> reg_rdata == {12'h000, $past(pair_independent_select)})
		else $error("mode read wrong");

	rd_status_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ce && reg_rd && reg_addr == `CPWM_ADDR_STATUS)
		|=> reg_rdata == {4'h0, $past(cmp), $past(out_bits)})
		else $error("status read wrong");

	rd_tbcnt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ce && reg_rd && reg_addr == `CPWM_ADDR_TBCNT)
		|=> reg_rdata == $past(tb_cnt))
		else $error("time base count read wrong");

	tb_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ce && pwm_timebase_on && tb_cnt < period)
		|=> tb_cnt == 16'($past(tb_cnt) + 16'h0001))
		else $error("time base did not count");

	tb_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ce && !pwm_timebase_on) |=> tb_cnt == 16'h0000)
		else $error("time base ran while off");
endmodule

// >>> cpwm_bridge.sv
// External push-pull transistor pair model that flags shoot-through
module cpwm_bridge (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Gate drives from the block
	input  wire logic high_gate,
	input  wire logic low_gate,
	// Fault seen on the pair
	output logic      shoot_thru
);
	timeunit 1ns;
	timeprecision 1ps;

	// Both transistors on shorts the supply rail; the flag sticks until reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			shoot_thru <= 1'b0;
		end else if (high_gate && low_gate) begin
			shoot_thru <= 1'b1;
		end
	end
endmodule

// >>> complementary_pwm_deadtime_tb.sv
// Self-checking bench for the complementary PWM block with dead-time insertion
`include "cpwm_defs.svh"
module complementary_pwm_deadtime_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys;
	logic        rst_n;
	logic        ce;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [4:1]  hi;
	logic [4:1]  lo;
	logic [4:1]  hi_q;
	logic [4:1]  lo_q;
	logic [3:1]  shoot;
	logic [7:0]  dead_cnt  [4:1];
	logic [7:0]  gap_act   [4:1];
	logic [7:0]  gap_inact [4:1];
	logic [7:0]  exp_a;
	logic [7:0]  frz;
	logic        ind_chk;
	logic        ind_err;
	int          mismatches;
	int          cmp_count;

	// ****************************************
	// Design, transistor pairs and monitors
	// ****************************************
	cpwm_top DUT (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pair1_high_out(hi[1]), .pair1_low_out(lo[1]),
		.pair2_high_out(hi[2]), .pair2_low_out(lo[2]),
		.pair3_high_out(hi[3]), .pair3_low_out(lo[3]),
		.pair4_high_out(hi[4]), .pair4_low_out(lo[4])
	);

	// Pairs 1 to 3 stay complementary, so each gets a transistor stage
	for (genvar n = 1; n <= 3; n++) begin : g_pair
		cpwm_bridge u_stage (
			.clk_sys(clk_sys), .rst_n(rst_n), .high_gate(hi[n]),
			.low_gate(lo[n]), .shoot_thru(shoot[n])
		);
	end

	// Counts cycles with both outputs off and records it at each turn-on
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			hi_q <= 4'h0;
			lo_q <= 4'h0;
			for (int n = 1; n <= 4; n++) begin
				dead_cnt[n] <= 8'h00;
				gap_act[n] <= 8'h00;
				gap_inact[n] <= 8'h00;
			end
		end else begin
			for (int n = 1; n <= 4; n++) begin
				if (hi[n] && !hi_q[n]) gap_act[n] <= dead_cnt[n];
				if (lo[n] && !lo_q[n]) gap_inact[n] <= dead_cnt[n];
				dead_cnt[n] <= (hi[n] || lo[n]) ? 8'h00 : dead_cnt[n] + 8'h01;
			end
			hi_q <= hi;
			lo_q <= lo;
		end
	end

	// Independent pair must show both outputs equal while ind_chk is set
	always @(negedge clk_sys) begin
		if (!rst_n) ind_err <= 1'b0;
		else if (ind_chk && (hi[4] !== lo[4])) ind_err <= 1'b1;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		check(what, reg_rdata, exp);
		@(posedge clk_sys);
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and test sequence
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Whole run needs about 1100 cycles; this cuts a hang short
	initial begin
		#250000;
		mismatches++;
		stop_test();
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ind_chk = 1'b0;
		mismatches = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Idle complementary pairs: compare low, so high off and low on
		@(posedge clk_sys);
		@(negedge clk_sys);
		check("outputs after reset", {8'h00, hi, lo}, 16'h000F);
		@(posedge clk_sys);
		rd(`CPWM_ADDR_CTRL, 16'h0000, "mode after reset");
		rd(`CPWM_ADDR_PERIOD, 16'h00FF, "period after reset");
		rd(`CPWM_ADDR_DTVAL, 16'h0000, "dead values after reset");
		rd(`CPWM_ADDR_DTASSIGN, 16'h0000, "assign after reset");
		wr(4'hF, 16'h1234);
		rd(4'hF, 16'h0000, "unmapped read");
		wr(`CPWM_ADDR_PERIOD, 16'h003F);
		for (int n = 0; n < 4; n++) wr(4'(`CPWM_ADDR_DUTY1 + n), 16'h001E);
		rd(`CPWM_ADDR_DUTY1, 16'h001E, "duty 1 readback");
		wr(`CPWM_ADDR_CTRL, 16'h0008);
		// Pair 1 active A inactive B, pair 2 all B, pair 3 all A
		wr(`CPWM_ADDR_DTASSIGN, 16'h000E);
		for (int ps = 0; ps < 4; ps++) begin
			wr(`CPWM_ADDR_TBASE, 16'h0000);
			wr(`CPWM_ADDR_DTVAL, {2'h1, 6'h03, 2'(ps), 6'h02});
			rd(`CPWM_ADDR_DTVAL, {2'h1, 6'h03, 2'(ps), 6'h02}, "dead values");
			wr(`CPWM_ADDR_TBASE, 16'h0001);
			repeat (200) @(posedge clk_sys);
			ind_chk = 1'b1;
			exp_a = 8'h02 << ps;
			for (int n = 1; n <= 3; n++) begin
				check("active edge gap", 16'(gap_act[n]),
					(n == 2) ? 16'h0006 : 16'(exp_a));
				check("inactive edge gap", 16'(gap_inact[n]),
					(n == 3) ? 16'(exp_a) : 16'h0006);
			end
		end
		// Zero counts switch at once with no off interval
		wr(`CPWM_ADDR_TBASE, 16'h0000);
		wr(`CPWM_ADDR_DTVAL, 16'h0000);
		wr(`CPWM_ADDR_TBASE, 16'h0001);
		repeat (200) @(posedge clk_sys);
		check("zero active gap", 16'(gap_act[1]), 16'h0000);
		check("zero inactive gap", 16'(gap_inact[3]), 16'h0000);
		check("independent pair equal", 16'(ind_err), 16'h0000);
		check("no shoot-through", 16'(shoot), 16'h0000);
		// Enable low for longer than any compare phase: outputs must not move
		ce <= 1'b0;
		@(negedge clk_sys);
		frz = {hi, lo};
		repeat (40) @(posedge clk_sys);
		ce <= 1'b1;
		@(negedge clk_sys);
		check("outputs frozen", 16'({hi, lo}), 16'(frz));
		@(posedge clk_sys);
		ind_chk = 1'b0;
		// Reset in mid-run returns every pair to complementary
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		check("outputs after second reset", {8'h00, hi, lo}, 16'h000F);
		@(posedge clk_sys);
		rd(`CPWM_ADDR_CTRL, 16'h0000, "mode after second reset");
		rd(`CPWM_ADDR_STATUS, 16'h00AA, "status after second reset");
		rd(`CPWM_ADDR_TBCNT, 16'h0000, "time base count after reset");
		stop_test();
	end
endmodule
